// File: psled_top.v
// port status indicator driver with a classic wishbone register slave
//
// How it works
// - each of six pins selectable as indicator
// - indicator pin: input buffer, pull-up off
// - function and select loaded from boot straps
// - global off: undriven, push-pull held inactive
// - codes 000b/001b pin assignment
// - codes 010b/011b pin assignment
// - codes 100b/101b assignment, 110b reserved
// - code 111b raw mii enables, unstretched
// - code 111b push-pull, others open drive
// - active drives inverse strap, inactive undriven
// - tx pulse 80 ms, gap 80 ms
// - rx pulse 80 ms, gap 80 ms
// - activity pulse 80 ms, needs link
// - link steady active while linked
// - link/activity pulses inactive on traffic
// - 100-link and 10-link follow speed
// - speed link/activity pulses at matching speed
// - full duplex steady, collision pulses half
// - speed active at 100, else inactive
// - select bit 0 general, 1 indicator
// - strap sampled high means active low
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "psled_consts.vh"

module psled_top #(
  parameter CNT_W = `PSLED_CNT_W,
  parameter [CNT_W-1:0] STRETCH_CYC = `PSLED_STRETCH_CYC
) (
  input wire mclk_i,
  input wire rst_n_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [11:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [2:0] strap_fun_i,
  input wire [5:0] strap_sel_i,
  input wire [5:0] strap_pol_i,
  input wire [1:0] link_i,
  input wire [1:0] spd100_i,
  input wire [1:0] fdx_i,
  input wire [1:0] col_i,
  input wire [2:0] tx_en_i,
  input wire [2:0] rx_dv_i,
  input wire [5:0] gpio_dout_i,
  input wire [5:0] gpio_oe_i,
  output reg [5:0] pin_o,
  output reg [5:0] pin_oe_o,
  output reg [5:0] ibuf_en_o,
  output reg [5:0] pullup_en_o
);

  // ----------------------------------------------------------------
  // indication kinds and pulse states
  // ----------------------------------------------------------------
  localparam [3:0] K_NONE = 4'h0;
  localparam [3:0] K_LINKACT = 4'h1;
  localparam [3:0] K_DUPCOL = 4'h2;
  localparam [3:0] K_SPEED = 4'h3;
  localparam [3:0] K_L100ACT = 4'h4;
  localparam [3:0] K_L10ACT = 4'h5;
  localparam [3:0] K_TX = 4'h6;
  localparam [3:0] K_RX = 4'h7;
  localparam [3:0] K_ACT = 4'h8;
  localparam [3:0] K_LINK = 4'h9;
  localparam [3:0] K_L10 = 4'hA;
  localparam [3:0] K_L100 = 4'hB;

  localparam [2:0] S_IDLE = 3'h1;
  localparam [2:0] S_PULSE = 3'h2;
  localparam [2:0] S_GAP = 3'h4;

  localparam [CNT_W-1:0] CNT_LAST = STRETCH_CYC - {{(CNT_W-1){1'b0}}, 1'b1};
  localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};

  // m is the pin position inside its group of three, 2 being the top pin
  function [3:0] kind_of;
    input [2:0] f;
    input [1:0] m;
    input hi;
    begin
      kind_of = K_NONE;
      case (f)
        3'h0: kind_of = (m == 2'h2) ? K_LINKACT : (m == 2'h1) ? K_DUPCOL : K_SPEED;
        3'h1: kind_of = (m == 2'h2) ? K_L100ACT : (m == 2'h1) ? K_DUPCOL : K_L10ACT;
        3'h2: kind_of = (m == 2'h2) ? (hi ? K_TX : K_RX) : (m == 2'h1) ? K_LINKACT : K_SPEED;
        3'h3: kind_of = (m == 2'h2) ? K_ACT : (m == 2'h1) ? K_LINK : K_SPEED;
        3'h4: kind_of = (m == 2'h2) ? K_ACT : (m == 2'h1) ? K_LINK : K_DUPCOL;
        3'h5: kind_of = (m == 2'h2) ? K_ACT : (m == 2'h1) ? K_L10 : K_L100;
        default: kind_of = K_NONE;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // configuration state
  // ----------------------------------------------------------------
  reg [2:0] fun_ff;
  reg [5:0] sel_ff;
  reg [5:0] pol_ff;
  reg off_ff;
  reg loaded_ff;

  wire req = wb_cyc_i & wb_stb_i;
  wire wr_go = req & wb_we_i & wb_ack_o;
  wire hit_cfg = wb_adr_i == `PSLED_CFG_ADDR;
  wire hit_pmc = wb_adr_i == `PSLED_PMC_ADDR;
  wire hit_sts = wb_adr_i == `PSLED_STS_ADDR;

  // straps are caught one edge after release, reset itself holds constants
  always @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      fun_ff <= `PSLED_CFG_FUN_RST;
      sel_ff <= `PSLED_CFG_SEL_RST;
      pol_ff <= 6'h00;
      off_ff <= `PSLED_PMC_OFF_RST;
      loaded_ff <= 1'b0;
    end
    else if (!loaded_ff)
    begin
      fun_ff <= strap_fun_i;
      sel_ff <= strap_sel_i;
      pol_ff <= strap_pol_i;
      loaded_ff <= 1'b1;
    end
    else if (wr_go)
    begin
      if (hit_cfg && wb_sel_i[0])
        sel_ff <= wb_dat_i[`PSLED_CFG_SEL_MSB:`PSLED_CFG_SEL_LSB];
      if (hit_cfg && wb_sel_i[1])
        fun_ff <= wb_dat_i[`PSLED_CFG_FUN_MSB:`PSLED_CFG_FUN_LSB];
      if (hit_pmc && wb_sel_i[0])
        off_ff <= wb_dat_i[`PSLED_PMC_OFF_BIT];
    end
  end

  // ----------------------------------------------------------------
  // per-pin indication and stretch timers
  // ----------------------------------------------------------------
  wire [5:0] act_w;

  genvar i;
  generate
    for (i = 0; i < 6; i = i + 1)
    begin : g_pin
      localparam integer POS_I = i % 3;
      localparam [1:0] POS = POS_I[1:0];
      localparam HI = (i >= 3);
      localparam PI = HI ? 1 : 0;
      localparam PN = HI ? 2 : 1;

      reg [2:0] st_ff;
      reg [CNT_W-1:0] cnt_ff;
      reg [2:0] nxt_st;
      reg [CNT_W-1:0] nxt_cnt;
      reg trig;
      reg act;

      wire [3:0] kind = kind_of(fun_ff, POS, HI);
      wire lk = link_i[PI];
      wire s1 = spd100_i[PI];
      wire fd = fdx_i[PI];
      wire cl = col_i[PI];
      wire ac = tx_en_i[PN] | rx_dv_i[PN];
      wire pulse = st_ff == S_PULSE;

      always @*
      begin
        trig = 1'b0;
        act = 1'b0;
        case (kind)
          K_TX:
          begin
            trig = tx_en_i[0];
            act = pulse;
          end
          K_RX:
          begin
            trig = rx_dv_i[0];
            act = pulse;
          end
          K_ACT:
          begin
            trig = lk & ac;
            act = lk & pulse;
          end
          K_LINK: act = lk;
          K_LINKACT:
          begin
            trig = lk & ac;
            act = lk & ~pulse;
          end
          K_L100: act = lk & s1;
          K_L10: act = lk & ~s1;
          K_L100ACT:
          begin
            trig = lk & s1 & ac;
            act = lk & s1 & ~pulse;
          end
          K_L10ACT:
          begin
            trig = lk & ~s1 & ac;
            act = lk & ~s1 & ~pulse;
          end
          K_DUPCOL:
          begin
            trig = lk & ~fd & cl;
            act = lk & (fd | pulse);
          end
          K_SPEED: act = lk & s1;
          default: act = 1'b0;
        endcase
      end

      // a new trigger is only looked at once the full gap has run out
      always @*
      begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        case (st_ff)
          S_IDLE:
          begin
            if (trig)
            begin
              nxt_st = S_PULSE;
              nxt_cnt = CNT_ZERO;
            end
          end
          S_PULSE:
          begin
            if (cnt_ff == CNT_LAST)
            begin
              nxt_st = S_GAP;
              nxt_cnt = CNT_ZERO;
            end
            else
              nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
          end
          S_GAP:
          begin
            if (cnt_ff == CNT_LAST)
              nxt_st = S_IDLE;
            else
              nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
          end
          default:
          begin
            nxt_st = S_IDLE;
            nxt_cnt = CNT_ZERO;
          end
        endcase
      end

      always @(posedge mclk_i)
      begin
        if (!rst_n_i)
        begin
          st_ff <= S_IDLE;
          cnt_ff <= CNT_ZERO;
        end
        else
        begin
          st_ff <= nxt_st;
          cnt_ff <= nxt_cnt;
        end
      end

      assign act_w[i] = act;
    end
  endgenerate

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  // raw order, pin 5 down to pin 0
  wire [5:0] raw_sig = {tx_en_i[0], tx_en_i[2], rx_dv_i[2], rx_dv_i[0], tx_en_i[1], rx_dv_i[1]};
  wire raw_md = fun_ff == `PSLED_FUN_RAW;
  wire rsv_md = fun_ff == `PSLED_FUN_RSVD;
  wire [5:0] off_v = {6{off_ff}};
  reg [5:0] led_oe;
  reg [5:0] led_out;

  always @*
  begin
    if (raw_md)
    begin
      led_oe = 6'h3F;
      led_out = raw_sig & ~off_v;
    end
    else
    begin
      // reserved code leaves every indicator undriven
      led_oe = act_w & ~off_v & {6{~rsv_md}};
      led_out = led_oe & ~pol_ff;
    end
  end

  always @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      pin_o <= 6'h00;
      pin_oe_o <= 6'h00;
      ibuf_en_o <= 6'h3F;
      pullup_en_o <= 6'h3F;
    end
    else
    begin
      pin_o <= (sel_ff & led_out) | (~sel_ff & gpio_dout_i);
      pin_oe_o <= (sel_ff & led_oe) | (~sel_ff & gpio_oe_i);
      ibuf_en_o <= ~sel_ff;
      pullup_en_o <= ~sel_ff;
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave, one wait state, unmapped reads return zero
  // ----------------------------------------------------------------
  reg [31:0] rd_mux;

  always @*
  begin
    rd_mux = 32'h0000_0000;
    if (hit_cfg)
    begin
      rd_mux[`PSLED_CFG_SEL_MSB:`PSLED_CFG_SEL_LSB] = sel_ff;
      rd_mux[`PSLED_CFG_FUN_MSB:`PSLED_CFG_FUN_LSB] = fun_ff;
    end
    else if (hit_pmc)
      rd_mux[`PSLED_PMC_OFF_BIT] = off_ff;
    else if (hit_sts)
    begin
      rd_mux[`PSLED_STS_ACT_LSB+5:`PSLED_STS_ACT_LSB] = raw_md ? raw_sig : act_w;
      rd_mux[`PSLED_STS_POL_LSB+5:`PSLED_STS_POL_LSB] = pol_ff;
    end
  end

  always @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= req & ~wb_ack_o;
      if (req & ~wb_ack_o)
        wb_dat_o <= rd_mux;
    end
  end

endmodule
`default_nettype wire

// File: psled_consts.vh
// constants of the port status indicator driver
`ifndef PSLED_CONSTS_VH
`define PSLED_CONSTS_VH

// register byte addresses
`define PSLED_CFG_ADDR 12'h1BC
`define PSLED_PMC_ADDR 12'h1C0
`define PSLED_STS_ADDR 12'h1C4

// indicator_config fields
`define PSLED_CFG_SEL_LSB 0
`define PSLED_CFG_SEL_MSB 5
`define PSLED_CFG_FUN_LSB 8
`define PSLED_CFG_FUN_MSB 10
`define PSLED_CFG_SEL_RST 6'h00
`define PSLED_CFG_FUN_RST 3'h0

// power_mgmt_control fields
`define PSLED_PMC_OFF_BIT 0
`define PSLED_PMC_OFF_RST 1'b0

// status fields
`define PSLED_STS_ACT_LSB 0
`define PSLED_STS_POL_LSB 8

// function codes
`define PSLED_FUN_RSVD 3'h6
`define PSLED_FUN_RAW 3'h7

// stretch timing
`define PSLED_STRETCH_MS 80
`define PSLED_CLK_KHZ 200000
// 80 ms at a 200 MHz clock, sized to the counter so the parameter takes it whole
`define PSLED_STRETCH_CYC 24'hF42400
`define PSLED_CNT_W 24

`endif

// File: psled_phy.sv
// far-side model: phy status lines and mii enables seen by the driver
`timescale 1ns/100ps
`default_nettype none
module psled_phy (
  input wire logic mclk_i,
  input wire logic [13:0] st_i,
  output var logic [1:0] link_o,
  output var logic [1:0] spd_o,
  output var logic [1:0] fdx_o,
  output var logic [1:0] col_o,
  output var logic [2:0] tx_o,
  output var logic [2:0] rx_o
);
  // phy status changes only on clock edges, as a registered phy would
  always_ff @(posedge mclk_i)
    {rx_o, tx_o, col_o, fdx_o, spd_o, link_o} <= st_i;
endmodule
`default_nettype wire

// File: psled_chk.sv
// assertion checker for the port status indicator driver
`timescale 1ns/100ps
`default_nettype none
module psled_chk (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic [2:0] strap_fun_i,
  input wire logic [5:0] strap_pol_i,
  input wire logic [2:0] tx_en_i,
  input wire logic [2:0] rx_dv_i,
  input wire logic [5:0] gpio_dout_i,
  input wire logic [5:0] gpio_oe_i,
  input wire logic [5:0] pin_o,
  input wire logic [5:0] pin_oe_o,
  input wire logic [5:0] ibuf_en_o,
  input wire logic [5:0] pullup_en_o
);
  // ----------------------------------------
  // config shadow
  // ----------------------------------------
  logic [2:0] fun_ff;
  logic off_ff;
  logic [1:0] up_ff;
  wire wr_w = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  wire [5:0] raw_w = {tx_en_i[0], tx_en_i[2], rx_dv_i[2], rx_dv_i[0], tx_en_i[1], rx_dv_i[1]};
  wire [5:0] led_w = ~ibuf_en_o;
  // straps settle into the registers only after release, so skip the first edges
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      fun_ff <= strap_fun_i;
      off_ff <= 1'b0;
      up_ff <= 2'h0;
    end
    else
    begin
      if (up_ff != 2'h3) up_ff <= up_ff + 2'h1;
      if (wr_w && wb_adr_i == 12'h1BC && wb_sel_i[1]) fun_ff <= wb_dat_i[10:8];
      if (wr_w && wb_adr_i == 12'h1C0 && wb_sel_i[0]) off_ff <= wb_dat_i[0];
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i || up_ff != 2'h3);
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ans_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  ack_resp_a: assert property (req_s |=> ans_s)
    else $error("bus answer late or long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  pad_ctrl_a: assert property (ibuf_en_o == pullup_en_o)
    else $error("buffer and pull-up differ");
  raw_pins_a: assert property (fun_ff == 3'h7 && !off_ff |=>
    ((pin_o ^ $past(raw_w)) & led_w) == 6'h00 && (led_w & ~pin_oe_o) == 6'h00)
    else $error("raw pin wrong");
  off_open_a: assert property (off_ff && fun_ff != 3'h7 |=> (pin_oe_o & led_w) == 6'h00)
    else $error("pin driven while off");
  off_raw_a: assert property (off_ff && fun_ff == 3'h7 |=> (led_w & (pin_o | ~pin_oe_o)) == 6'h00)
    else $error("push-pull pin not low while off");
  rsvd_code_a: assert property (fun_ff == 3'h6 |=> (pin_oe_o & led_w) == 6'h00)
    else $error("reserved code drives pin");
  act_level_a: assert property (fun_ff < 3'h6 |=> (led_w & ((pin_oe_o & (pin_o ^ ~strap_pol_i))
    | (~pin_oe_o & pin_o))) == 6'h00)
    else $error("indicator level wrong");
  gpio_pass_a: assert property (up_ff == 2'h3 |=> (ibuf_en_o & ((pin_o ^ $past(gpio_dout_i))
    | (pin_oe_o ^ $past(gpio_oe_i)))) == 6'h00)
    else $error("general pin not passed");
endmodule
bind psled_top psled_chk psled_chk_i (.*);
`default_nettype wire

// File: testbench.sv
// self-checking bench for the port status indicator driver
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int STR = 20;
  localparam logic [5:0] POL = 6'h15;
  // pin function per code, one nibble a pin, pin 5 first
  localparam logic [23:0] TBL [8] = '{24'h123123, 24'h425425, 24'h613713, 24'h893893,
    24'h892892, 24'h8AB8AB, 24'h000000, 24'h000000};
  logic mclk_i = 0, rst_n_i = 0, wb_cyc_i = 0, wb_we_i = 0;
  logic [11:0] wb_adr_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, rd, sd = 32'h47A6;
  logic [13:0] st = 0;
  logic [5:0] gpio_dout_i = 0, gpio_oe_i = 0, pin_o, pin_oe_o, ibuf_en_o, pullup_en_o;
  logic [1:0] link_i, spd100_i, fdx_i, col_i;
  logic [2:0] tx_en_i, rx_dv_i;
  logic wb_ack_o, lo;
  int err_count = 0, checked = 0, n;
  always #2.5 mclk_i = ~mclk_i;
  psled_top #(.STRETCH_CYC(STR)) psled_top_i (.*, .wb_stb_i(wb_cyc_i), .wb_sel_i(4'hF),
    .strap_fun_i(3'h5), .strap_sel_i(6'h3F), .strap_pol_i(POL));
  psled_phy psled_phy_i (.mclk_i, .st_i(st), .link_o(link_i), .spd_o(spd100_i), .fdx_o(fdx_i),
    .col_o(col_i), .tx_o(tx_en_i), .rx_o(rx_dv_i));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic print_verdict;
    $display("mismatches %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk_i);
    wb_cyc_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    k = 0;
    do
    begin
      @(posedge mclk_i);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 0;
    if (wb_ack_o !== 1'b1)
    begin
      err_count++;
      print_verdict();
    end
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // random status, select and general pins; traffic only where it is unstretched
  task automatic stat(input int c, input logic off);
    logic [5:0] s, ep, eo, r;
    int t, p;
    logic lg;
    sd = lfsr(sd);
    s = sd[5:0];
    gpio_dout_i <= sd[11:6];
    gpio_oe_i <= sd[17:12];
    st <= {sd[31:26] & {6{c == 7}}, 2'b0, sd[23:18]};
    wb(1, 12'h1BC, {21'h0, c[2:0], 2'h0, s});
    wb(1, 12'h1C0, {31'h0, off});
    repeat (4) @(posedge mclk_i);
    r = {st[8], st[10], st[13], st[11], st[9], st[12]};
    for (int i = 0; i < 6; i++)
    begin
      p = i / 3;
      t = TBL[c][i*4 +: 4];
      lg = st[p] & (t == 1 || t == 9 || (t == 2 && st[4+p]) ||
        ((t == 3 || t == 4 || t == 11) && st[2+p]) || ((t == 5 || t == 10) && !st[2+p]));
      eo[i] = s[i] ? (c == 7 || (lg && !off)) : gpio_oe_i[i];
      ep[i] = s[i] ? (c == 7 ? r[i] && !off : eo[i] && !POL[i]) : gpio_dout_i[i];
    end
    chk("pin_oe", pin_oe_o, eo);
    chk("pin", pin_o, ep);
    chk("ibuf", ibuf_en_o, {26'h0, ~s});
    chk("pullup", pullup_en_o, {26'h0, ~s});
  endtask
  // one stretched pulse on pin i of code c; a is the drive enable while the pulse runs
  task automatic pulse(input string nm, input logic [2:0] c, input logic [13:0] b,
    input logic [13:0] t, input int i, input logic a);
    wb(1, 12'h1BC, {21'h0, c, 2'h0, 6'h3F});
    st <= b;
    // long enough for any timer still running to finish its gap
    repeat (3 * STR) @(posedge mclk_i);
    chk({nm, "_idle"}, pin_oe_o[i], !a);
    st <= t;
    @(posedge mclk_i);
    st <= b;
    for (n = 0; pin_oe_o[i] !== a && n < 10; n++)
      @(posedge mclk_i);
    for (n = 0; pin_oe_o[i] === a && n < 100; n++)
      @(posedge mclk_i);
    chk(nm, n, STR);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1;
    repeat (2) @(posedge mclk_i);
    wb(0, 12'h1BC, 0);
    chk("cfg_rst", rd, 32'h53F);
    wb(0, 12'h1C4, 0);
    chk("sts", rd, {POL, 8'h00});
    wb(1, 12'h1BC, '1);
    wb(0, 12'h1BC, 0);
    chk("cfg_rsv", rd, 32'h73F);
    wb(0, 12'h200, 0);
    chk("unmapped", rd, 0);
    for (int c = 0; c < 8; c++)
      stat(c, 0);
    stat(7, 1);
    stat(0, 1);
    // let any timers started by the raw traffic run out
    repeat (3 * STR) @(posedge mclk_i);
    st <= 14'h0001;
    wb(1, 12'h1C0, 0);
    wb(1, 12'h1BC, 32'h3F);
    repeat (3) @(posedge mclk_i);
    chk("la_idle", pin_oe_o[2], 1'b1);
    st <= 14'h0201;
    @(posedge mclk_i);
    st <= 14'h0001;
    for (n = 0; pin_oe_o[2] !== 1'b0 && n < 10; n++)
      @(posedge mclk_i);
    for (n = 0; pin_oe_o[2] === 1'b0 && n < 100; n++)
      @(posedge mclk_i);
    chk("la_pulse", n, STR);
    st <= 14'h0201;
    @(posedge mclk_i);
    st <= 14'h0001;
    lo = 0;
    repeat (STR - 4)
    begin
      @(posedge mclk_i);
      lo = lo | ~pin_oe_o[2];
    end
    chk("la_gap", lo, 0);
    pulse("tx", 3'h2, 14'h0000, 14'h0100, 5, 1'b1);
    pulse("rx", 3'h2, 14'h0000, 14'h0800, 2, 1'b1);
    pulse("act", 3'h3, 14'h0002, 14'h2002, 5, 1'b1);
    pulse("l100act", 3'h1, 14'h0005, 14'h1005, 2, 1'b0);
    pulse("dupcol", 3'h0, 14'h0001, 14'h0041, 1, 1'b1);
    print_verdict();
  end
endmodule
`default_nettype wire
